// ### comparator_reference_control.sv
/*
  comparator voltage reference control: apb register slave, ladder tap decode,
  clamp and current gating, fixed reference enable, comparator source selects.
  assumes a zero-wait apb master on pclk; the oscillator status is asynchronous.
*/
`timescale 1ns/100ps
module comparator_reference_control
    import ref_ctrl_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ref_ctrl_pkg::ADDR_W-1:0] paddr,
    input wire logic [ref_ctrl_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [ref_ctrl_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // oscillator status
    input wire logic fast_internal_oscillator,
    // ladder
    output logic ladder_power_enable,
    output logic ladder_range_select,
    output logic [ref_ctrl_pkg::CODE_W-1:0] ladder_level_code,
    output logic [ref_ctrl_pkg::TAP_W-1:0] ladder_tap_num,
    output logic ladder_tap_div24,
    output logic ladder_current_on,
    output logic ladder_clamp_ground,
    // fixed reference
    output logic fixed_reference_on,
    // comparator sources
    output logic cmp1_route_ladder,
    output logic cmp1_route_fixed,
    output logic cmp2_route_ladder,
    output logic cmp2_route_fixed
);
    import ref_ctrl_pkg::*;

    typedef struct packed {
        apb_phase_t phase;
        logic [7:0] ctrl;
        logic ladder_en;
        logic [OSC_SYNC_N-1:0] osc_sync;
        logic osc_agreed;
        logic [DATA_W-1:0] rdata;
        logic ladder_on;
        logic range_low;
        logic [CODE_W-1:0] code;
        logic [TAP_W-1:0] tap_num;
        logic tap_div24;
        logic current_on;
        logic clamp;
        logic fixed_on;
        logic c1_ladder;
        logic c1_fixed;
        logic c2_ladder;
        logic c2_fixed;
    } state_t;

    // reset image is consistent with ctrl = 0: high range, fixed source routed
    localparam state_t STATE_RESET = '{
        phase: PH_IDLE,
        ctrl: CTRL_RESET,
        ladder_en: LADDER_EN_RESET,
        osc_sync: '0,
        osc_agreed: 1'b0,
        rdata: '0,
        ladder_on: LADDER_EN_RESET,
        range_low: 1'b0,
        code: CODE_ZERO,
        tap_num: HIGH_BASE,
        tap_div24: 1'b0,
        current_on: 1'b0,
        clamp: 1'b0,
        fixed_on: 1'b0,
        c1_ladder: 1'b0,
        c1_fixed: 1'b1,
        c2_ladder: 1'b0,
        c2_fixed: 1'b1
    };

    state_t state_reg;
    state_t state_next;

    logic setup_cyc;
    logic access_cyc;
    logic hit_ctrl;
    logic hit_ladder_en;
    logic hit_status;
    logic addr_hit;
    logic wr_ok;
    logic [7:0] ctrl_d;
    logic ladder_en_d;
    logic osc_agreed_d;
    logic clamp_d;
    logic [TAP_W-1:0] tap_num_d;
    logic tap_div24_d;
    logic c1_ladder_d;
    logic c1_fixed_d;
    logic c1_want;
    logic c2_ladder_d;
    logic c2_fixed_d;
    logic c2_want;
    logic [DATA_W-1:0] read_word;

    // bus decode
    assign setup_cyc = psel && !penable;
    assign access_cyc = psel && penable && (state_reg.phase == PH_SETUP);
    assign hit_ctrl = (paddr == OFF_CTRL);
    assign hit_ladder_en = (paddr == OFF_LADDER_EN);
    assign hit_status = (paddr == OFF_STATUS);
    assign addr_hit = hit_ctrl || hit_ladder_en || hit_status;
    // only byte lane 0 carries implemented bits
    assign wr_ok = access_cyc && pwrite && pstrb[0];

    assign ctrl_d = (wr_ok && hit_ctrl) ? pwdata[7:0] : state_reg.ctrl;
    assign ladder_en_d = (wr_ok && hit_ladder_en) ? pwdata[0] : state_reg.ladder_en;

    // oscillator change counts once second and third stages agree
    assign osc_agreed_d = (state_reg.osc_sync[1] == state_reg.osc_sync[2])
        ? state_reg.osc_sync[2] : state_reg.osc_agreed;

    ladder_tap_decoder u_tap (
        .range_low(ctrl_d[RANGE_BIT]),
        .code(ctrl_d[CODE_LSB +: CODE_W]),
        .tap_num(tap_num_d),
        .tap_div24(tap_div24_d)
    );

    comparator_source_mux u_cmp1 (
        .ladder_select(ctrl_d[CMP1_SEL_BIT]),
        .route_ladder(c1_ladder_d),
        .route_fixed(c1_fixed_d),
        .wants_current(c1_want)
    );

    comparator_source_mux u_cmp2 (
        .ladder_select(ctrl_d[CMP2_SEL_BIT]),
        .route_ladder(c2_ladder_d),
        .route_fixed(c2_fixed_d),
        .wants_current(c2_want)
    );

    // clamp wins over the selects so the zero-crossing setup draws nothing
    assign clamp_d = !ladder_en_d && ctrl_d[RANGE_BIT] &&
        (ctrl_d[CODE_LSB +: CODE_W] == CODE_ZERO);

    always_comb begin
        read_word = '0;
        if (hit_ctrl) begin
            read_word[7:0] = state_reg.ctrl;
        end else if (hit_ladder_en) begin
            read_word[0] = state_reg.ladder_en;
        end else if (hit_status) begin
            read_word[ST_CLAMP_BIT] = state_reg.clamp;
            read_word[ST_CURRENT_BIT] = state_reg.current_on;
            read_word[ST_FIXED_BIT] = state_reg.fixed_on;
            read_word[ST_OSC_BIT] = state_reg.osc_agreed;
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg.phase)
            PH_IDLE: begin
                if (setup_cyc) begin
                    state_next.phase = PH_SETUP;
                end
            end
            PH_SETUP: begin
                state_next.phase = (psel && penable) ? PH_ACCESS : PH_IDLE;
            end
            PH_ACCESS: begin
                state_next.phase = setup_cyc ? PH_SETUP : PH_IDLE;
            end
            default: begin
                state_next.phase = PH_IDLE;
            end
        endcase
        // read data is captured in setup so it leaves a flop in access
        if (setup_cyc) begin
            state_next.rdata = read_word;
        end
        state_next.ctrl = ctrl_d;
        state_next.ladder_en = ladder_en_d;
        state_next.osc_sync = {state_reg.osc_sync[1:0], fast_internal_oscillator};
        state_next.osc_agreed = osc_agreed_d;
        state_next.ladder_on = ladder_en_d;
        state_next.range_low = ctrl_d[RANGE_BIT];
        state_next.code = ctrl_d[CODE_LSB +: CODE_W];
        state_next.tap_num = tap_num_d;
        state_next.tap_div24 = tap_div24_d;
        state_next.clamp = clamp_d;
        state_next.current_on = (c1_want || c2_want) && !clamp_d;
        state_next.fixed_on = ctrl_d[FIXED_EN_BIT] || osc_agreed_d;
        state_next.c1_ladder = c1_ladder_d;
        state_next.c1_fixed = c1_fixed_d;
        state_next.c2_ladder = c2_ladder_d;
        state_next.c2_fixed = c2_fixed_d;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs
    assign prdata = state_reg.rdata;
    assign pready = psel && penable;
    assign pslverr = psel && penable && !addr_hit;
    assign ladder_power_enable = state_reg.ladder_on;
    assign ladder_range_select = state_reg.range_low;
    assign ladder_level_code = state_reg.code;
    assign ladder_tap_num = state_reg.tap_num;
    assign ladder_tap_div24 = state_reg.tap_div24;
    assign ladder_current_on = state_reg.current_on;
    assign ladder_clamp_ground = state_reg.clamp;
    assign fixed_reference_on = state_reg.fixed_on;
    assign cmp1_route_ladder = state_reg.c1_ladder;
    assign cmp1_route_fixed = state_reg.c1_fixed;
    assign cmp2_route_ladder = state_reg.c2_ladder;
    assign cmp2_route_fixed = state_reg.c2_fixed;

    // checks
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic ctrl_wr;
    logic en_wr;
    assign ctrl_wr = psel && penable && pwrite && pstrb[0] && hit_ctrl;
    assign en_wr = psel && penable && pwrite && pstrb[0] && hit_ladder_en;

    AST_LADDER_EN_ONLY: assert property (
        en_wr |=> (ladder_power_enable == $past(pwdata[0]))
    ) else $error("ladder enable does not follow its register");

    AST_LADDER_EN_INDEP: assert property (
        (ctrl_wr && !en_wr) |=> $stable(ladder_power_enable)
    ) else $error("comparator setup changed ladder enable");

    AST_RANGE_SEL: assert property (
        ctrl_wr |=> (ladder_range_select == $past(pwdata[RANGE_BIT]))
            && (ladder_tap_div24 == ladder_range_select)
    ) else $error("range select wrong");

    AST_LEVEL_CODE: assert property (
        ctrl_wr |=> (ladder_level_code == $past(pwdata[CODE_LSB +: CODE_W]))
    ) else $error("level code not taken from write");

    AST_LOW_TAP: assert property (
        ladder_tap_div24 |-> (ladder_tap_num == {1'b0, ladder_level_code})
    ) else $error("low range tap wrong");

    AST_HIGH_TAP: assert property (
        !ladder_tap_div24 |->
            (ladder_tap_num == ({1'b0, ladder_level_code} + HIGH_BASE))
    ) else $error("high range tap wrong");

    AST_CLAMP: assert property (
        ladder_clamp_ground == (!ladder_power_enable && ladder_range_select &&
            (ladder_level_code == CODE_ZERO))
    ) else $error("clamp state wrong");

    AST_CLAMP_NO_CURRENT: assert property (
        ladder_clamp_ground |-> !ladder_current_on
    ) else $error("ladder current while clamped");

    AST_FIXED_EN: assert property (
        (ctrl_wr && pwdata[FIXED_EN_BIT]) |=> fixed_reference_on
    ) else $error("fixed reference not enabled by write");

    AST_OSC_FORCE: assert property (
        fast_internal_oscillator [*5] |=> fixed_reference_on
    ) else $error("running oscillator did not force fixed reference");

    AST_FIXED_OFF: assert property (
        (!fast_internal_oscillator [*5] ##1 (ctrl_wr && !pwdata[FIXED_EN_BIT]))
            |=> !fixed_reference_on
    ) else $error("fixed reference stayed on");

    AST_CMP1_ROUTE: assert property (
        ctrl_wr |=> (cmp1_route_ladder == $past(pwdata[CMP1_SEL_BIT]))
            && (cmp1_route_fixed != cmp1_route_ladder)
    ) else $error("comparator one route wrong");

    AST_CMP2_ROUTE: assert property (
        ctrl_wr |=> (cmp2_route_ladder == $past(pwdata[CMP2_SEL_BIT]))
            && (cmp2_route_fixed != cmp2_route_ladder)
    ) else $error("comparator two route wrong");

    AST_CURRENT_GATE: assert property (
        ladder_current_on ==
            ((cmp1_route_ladder || cmp2_route_ladder) && !ladder_clamp_ground)
    ) else $error("ladder current gating wrong");

    AST_WRITE_UPDATE: assert property (
        (ctrl_wr && $stable(ladder_level_code) &&
            (pwdata[CODE_LSB +: CODE_W] != ladder_level_code))
            |=> $changed(ladder_level_code)
    ) else $error("outputs not updated on the write edge");

    // read data must be the register image held through the access cycle
    AST_READ_CTRL: assert property (
        (psel && penable && !pwrite && hit_ctrl) |->
            (prdata[7:0] == state_reg.ctrl) && (prdata[DATA_W-1:8] == '0)
    ) else $error("control read data wrong");

    AST_READ_UNMAPPED: assert property (
        (psel && penable && !pwrite && !addr_hit) |-> (prdata == '0)
    ) else $error("unmapped read data not zero");

    // a refused write must leave every stored bit alone
    AST_REFUSED_WRITE: assert property (
        (psel && penable && pwrite && (!pstrb[0] || hit_status)) |=>
            ($stable(state_reg.ctrl) && $stable(ladder_power_enable))
    ) else $error("refused write changed a register");

    AST_FIXED_OR: assert property (
        fixed_reference_on == (state_reg.ctrl[FIXED_EN_BIT] || state_reg.osc_agreed)
    ) else $error("fixed reference enable wrong");

    // a pin change is only taken once the last two stages agree
    AST_SYNC_AGREE: assert property (
        (state_reg.osc_sync[2] != state_reg.osc_sync[1]) |=> $stable(state_reg.osc_agreed)
    ) else $error("oscillator status taken before stages agreed");

    COV_CTRL_WRITE: cover property (ctrl_wr ##1 cmp1_route_ladder);
    COV_CLAMP: cover property ($rose(ladder_clamp_ground));
    COV_OSC_FORCE: cover property (
        fixed_reference_on && !state_reg.ctrl[FIXED_EN_BIT]);
    COV_BOTH_LADDER: cover property (
        cmp1_route_ladder && cmp2_route_ladder && ladder_current_on);
    COV_REFUSED: cover property (psel && penable && pslverr);

endmodule : comparator_reference_control

// ### ref_ctrl_pkg.sv
/*
  constants, register map and shared types for the comparator reference control.
  assumes a 32-bit apb master on pclk and an analog ladder that decodes the tap outputs.
*/
package ref_ctrl_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 12;
    localparam int CODE_W = 4;
    localparam int TAP_W = 5;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFF_CTRL = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_LADDER_EN = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h008;

    // reference_control fields
    localparam int CMP1_SEL_BIT = 7;
    localparam int CMP2_SEL_BIT = 6;
    localparam int RANGE_BIT = 5;
    localparam int FIXED_EN_BIT = 4;
    localparam int CODE_LSB = 0;

    // status fields
    localparam int ST_CLAMP_BIT = 0;
    localparam int ST_CURRENT_BIT = 1;
    localparam int ST_FIXED_BIT = 2;
    localparam int ST_OSC_BIT = 3;

    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic LADDER_EN_RESET = 1'b0;

    // high range sits a quarter up the 32-step ladder
    localparam logic [TAP_W-1:0] HIGH_BASE = 5'h08;
    localparam logic [CODE_W-1:0] CODE_ZERO = 4'h0;

    // oscillator status synchroniser depth
    localparam int OSC_SYNC_N = 3;

    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_SETUP = 2'b01,
        PH_ACCESS = 2'b11
    } apb_phase_t;

endpackage : ref_ctrl_pkg

// ### ladder_tap_decoder.sv
/*
  maps range and level code onto a ladder tap numerator and divider choice.
  assumes the ladder offers a 24-step string and a 32-step string.
*/
`timescale 1ns/100ps
module ladder_tap_decoder
    import ref_ctrl_pkg::*;
(
    // control
    input wire logic range_low,
    input wire logic [ref_ctrl_pkg::CODE_W-1:0] code,
    // tap
    output logic [ref_ctrl_pkg::TAP_W-1:0] tap_num,
    output logic tap_div24
);
    always_comb begin
        tap_div24 = range_low;
        if (range_low) begin
            tap_num = {1'b0, code};
        end else begin
            tap_num = {1'b0, code} + HIGH_BASE;
        end
    end
endmodule : ladder_tap_decoder

// ### comparator_source_mux.sv
/*
  per-comparator reference source select, one instance per comparator.
  assumes the analog mux is break-before-make on its own.
*/
`timescale 1ns/100ps
module comparator_source_mux (
    // select
    input wire logic ladder_select,
    // routes
    output logic route_ladder,
    output logic route_fixed,
    output logic wants_current
);
    // exactly one source is routed at any time
    always_comb begin
        route_ladder = ladder_select;
        route_fixed = !ladder_select;
        wants_current = ladder_select;
    end
endmodule : comparator_source_mux

// ### comparator_ladder_model.sv
/*
  behavioural model of the analog ladder and the two comparator reference inputs.
  assumes the control outputs of the reference control block drive it directly.
*/
`timescale 1ns/100ps
module comparator_ladder_model
    import ref_ctrl_pkg::*;
#(
    parameter int VDD_MV = 4800,
    parameter int FIXED_MV = 600
) (
    // ladder and fixed reference controls
    input wire logic [ref_ctrl_pkg::TAP_W-1:0] tap_num,
    input wire logic tap_div24,
    input wire logic clamp_ground,
    input wire logic current_on,
    input wire logic fixed_on,
    // comparator routes
    input wire logic r1_ladder,
    input wire logic r1_fixed,
    input wire logic r2_ladder,
    input wire logic r2_fixed,
    // levels in millivolts
    output logic [15:0] ladder_mv,
    output logic [15:0] cmp1_mv,
    output logic [15:0] cmp2_mv
);
    import ref_ctrl_pkg::*;

    logic [15:0] fix_mv;

    always_comb begin
        // no current and no clamp leaves the node floating: show junk, not a level
        if (clamp_ground) begin
            ladder_mv = 16'h0000;
        end else if (!current_on) begin
            ladder_mv = 16'hffff;
        end else if (tap_div24) begin
            ladder_mv = 16'(int'(tap_num) * VDD_MV / 24);
        end else begin
            ladder_mv = 16'(int'(tap_num) * VDD_MV / 32);
        end
        fix_mv = fixed_on ? 16'(FIXED_MV) : 16'hffff;
        cmp1_mv = r1_ladder ? ladder_mv : (r1_fixed ? fix_mv : 16'hfffe);
        cmp2_mv = r2_ladder ? ladder_mv : (r2_fixed ? fix_mv : 16'hfffe);
    end

endmodule : comparator_ladder_model

// ### test_comparator_reference_control.sv
/*
  self-checking bench for the comparator reference control.
  assumes the design files and the ladder model are compiled first.
*/
`timescale 1ns/100ps
module test_comparator_reference_control;
    import ref_ctrl_pkg::*;
    localparam int VDD_MV = 4800;
    logic pclk, presetn, psel, penable, pwrite, osc, pready, pslverr, err;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic l_en, l_rng, tap24, cur_on, clamp, fix_on, c1_lad, c1_fix, c2_lad, c2_fix;
    logic [CODE_W-1:0] l_code;
    logic [TAP_W-1:0] tap;
    logic [15:0] lad_mv, c1_mv, c2_mv;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;

    comparator_reference_control u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .fast_internal_oscillator(osc), .ladder_power_enable(l_en),
        .ladder_range_select(l_rng), .ladder_level_code(l_code),
        .ladder_tap_num(tap), .ladder_tap_div24(tap24), .ladder_current_on(cur_on),
        .ladder_clamp_ground(clamp), .fixed_reference_on(fix_on),
        .cmp1_route_ladder(c1_lad), .cmp1_route_fixed(c1_fix),
        .cmp2_route_ladder(c2_lad), .cmp2_route_fixed(c2_fix)
    );

    comparator_ladder_model #(.VDD_MV(VDD_MV)) u_model (
        .tap_num(tap), .tap_div24(tap24), .clamp_ground(clamp), .current_on(cur_on),
        .fixed_on(fix_on), .r1_ladder(c1_lad), .r1_fixed(c1_fix), .r2_ladder(c2_lad),
        .r2_fixed(c2_fix), .ladder_mv(lad_mv), .cmp1_mv(c1_mv), .cmp2_mv(c2_mv)
    );

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // one apb transfer; no wait count assumed, the global timeout ends a hang
    task apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
             input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge pclk);
    endtask : apb

    task t_reset;
        @(negedge pclk);
        chk("tap", 32'h8, 32'(tap));
        chk("cmp1 fixed", 32'h1, 32'(c1_fix));
        chk("cmp2 fixed", 32'h1, 32'(c2_fix));
        chk("current", 32'h0, 32'(cur_on));
        apb(1'b0, OFF_CTRL, 32'h0, 4'hf);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b0, OFF_LADDER_EN, 32'h0, 4'hf);
        chk("ladder reset", 32'h0, rd);
    endtask : t_reset

    task t_levels;
        int e;
        apb(1'b1, OFF_LADDER_EN, 32'h1, 4'hf);
        for (int r = 0; r < 2; r++) begin
            for (int c = 0; c < 16; c++) begin
                apb(1'b1, OFF_CTRL, 32'(128 + r * 32 + c), 4'h1);
                e = r ? c * VDD_MV / 24 : VDD_MV / 4 + c * VDD_MV / 32;
                chk("range", 32'(r), 32'(l_rng));
                chk("code", 32'(c), 32'(l_code));
                chk("cmp1 mv", 32'(e), 32'(c1_mv));
                chk("clamp", 32'h0, 32'(clamp));
            end
        end
        apb(1'b0, OFF_CTRL, 32'h0, 4'hf);
        chk("ctrl read", 32'haf, rd);
    endtask : t_levels

    task t_clamp;
        apb(1'b1, OFF_CTRL, 32'he0, 4'h1);
        chk("current", 32'h1, 32'(cur_on));
        apb(1'b1, OFF_LADDER_EN, 32'h0, 4'hf);
        chk("ladder en", 32'h0, 32'(l_en));
        chk("clamp", 32'h1, 32'(clamp));
        chk("current", 32'h0, 32'(cur_on));
        chk("cmp1 mv", 32'h0, 32'(c1_mv));
        apb(1'b0, OFF_STATUS, 32'h0, 4'hf);
        chk("status clamp", 32'h1, rd);
        apb(1'b1, OFF_LADDER_EN, 32'h1, 4'hf);
        chk("ladder en", 32'h1, 32'(l_en));
        chk("clamp", 32'h0, 32'(clamp));
    endtask : t_clamp

    task t_select;
        logic [1:0] s;
        for (int i = 0; i < 4; i++) begin
            s = 2'(i);
            apb(1'b1, OFF_CTRL, 32'(i * 64 + 16 + 5), 4'h1);
            chk("cmp1 ladder", 32'(s[1]), 32'(c1_lad));
            chk("cmp1 fixed", 32'(!s[1]), 32'(c1_fix));
            chk("cmp2 ladder", 32'(s[0]), 32'(c2_lad));
            chk("cmp2 mv", s[0] ? 32'd1950 : 32'd600, 32'(c2_mv));
            chk("current", 32'(s != 2'b00), 32'(cur_on));
        end
        apb(1'b0, OFF_STATUS, 32'h0, 4'hf);
        chk("status select", 32'h6, rd);
    endtask : t_select

    task t_fixed;
        apb(1'b1, OFF_CTRL, 32'h0, 4'h1);
        chk("fixed off", 32'h0, 32'(fix_on));
        apb(1'b1, OFF_CTRL, 32'h10, 4'h1);
        chk("fixed on", 32'h1, 32'(fix_on));
        // software settling pause before the fixed level is trusted
        repeat (20) @(posedge pclk);
        apb(1'b1, OFF_CTRL, 32'h0, 4'h1);
        @(posedge pclk);
        osc <= 1'b1;
        repeat (8) @(posedge pclk);
        @(negedge pclk);
        chk("osc forces", 32'h1, 32'(fix_on));
        apb(1'b0, OFF_STATUS, 32'h0, 4'hf);
        chk("status osc", 32'hc, rd);
        @(posedge pclk);
        osc <= 1'b0;
        repeat (8) @(posedge pclk);
        @(negedge pclk);
        chk("osc gone", 32'h0, 32'(fix_on));
    endtask : t_fixed

    task t_refused;
        apb(1'b0, 12'h00c, 32'h0, 4'hf);
        chk("unmapped err", 32'h1, 32'(err));
        chk("unmapped data", 32'h0, rd);
        apb(1'b1, OFF_CTRL, 32'h2f, 4'h0);
        apb(1'b0, OFF_CTRL, 32'h0, 4'hf);
        chk("strobe off", 32'h0, rd);
        apb(1'b1, OFF_STATUS, 32'hf, 4'h1);
        chk("status err", 32'h0, 32'(err));
        apb(1'b0, OFF_STATUS, 32'h0, 4'hf);
        chk("status kept", 32'h0, rd);
    endtask : t_refused

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'h0;
        osc = 1'b0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_levels();
        t_clamp();
        t_select();
        t_fixed();
        t_refused();
        report_and_stop();
    end

endmodule : test_comparator_reference_control
